// ===== src/valve_state_decoder.sv
/*
 valve state decoder top: wishbone slave, process image mapping, pilot
 gating with safety positions and top indicator code.
 assumes sensor, fault and link-loss inputs are synchronous to clk_i and
 that the controller writes the process output image over wishbone.
*/
`include "valve_state_decoder_cfg.svh"

module valve_state_decoder (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// taught target positions
	input  wire logic        target_pos_one_i,
	input  wire logic        target_pos_two_i,
	input  wire logic        target_pos_three_i,
	input  wire logic        target_pos_four_i,
	// supervision
	input  wire logic        link_lost_i,
	input  wire logic        internal_fault_i,
	input  wire logic        supply_bad_i,
	// actuators and display
	output logic             main_stroke_pilot_o,
	output logic             upper_lift_pilot_o,
	output logic             lower_lift_pilot_o,
	output logic             localise_o,
	output logic [2:0]       indicator_o
);

	typedef struct packed {
		logic [31:0]                          rdata;
		logic                                 ack;
		valve_state_decoder_pkg::variant_type variant;
		logic [2:0]                           safe_pattern;
		logic [7:0]                           process_output_image;
		logic [3:0]                           targets;
		logic                                 main;
		logic                                 upper;
		logic                                 lower;
		logic                                 localise;
		valve_state_decoder_pkg::indicator_type indicator;
	} top_state_type;

	top_state_type s_q;
	top_state_type s_d;

	logic [3:0] dec_state;
	logic [`VSD_IN_WIDTH-1:0] process_input_image;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic        wb_req;
	logic [2:0]  want;
	logic [2:0]  have;

	decode_if dec ();

	assign dec.targets = s_q.targets;
	assign dec.variant = s_q.variant;
	assign dec_state   = dec.state;

	valve_decode_table u_table (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.dec      (dec)
	);

	// input image: sensors at 0..3, valve state at 80..83
	always_comb begin
		process_input_image = '0;
		process_input_image[0] = s_q.targets[3];
		process_input_image[1] = s_q.targets[2];
		process_input_image[2] = s_q.targets[1];
		process_input_image[3] = s_q.targets[0];
		process_input_image[`VSD_IN_STATE_LSB +: 4] = dec_state;
	end

	assign ctrl_word = {25'h0, s_q.safe_pattern, 2'h0, s_q.variant};
	assign status_word = {21'h0, s_q.indicator, 4'h0,
		internal_fault_i | supply_bad_i, link_lost_i, 2'h0};
	assign wb_req = wb_cyc_i & wb_stb_i & ~s_q.ack;

	// pilots present in each variant; single-acting has only main
	always_comb begin
		if (s_q.variant == valve_state_decoder_pkg::VARIANT_SINGLE) begin
			have = 3'h1;
		end else begin
			have = 3'h7;
		end
		// only bits 0..2 steer pilots; bits 4-7 are only read back over wishbone
		want = s_q.process_output_image[2:0] & have;
	end

	always_comb begin
		s_d = s_q;
		s_d.ack = wb_req;
		s_d.targets = {target_pos_one_i, target_pos_two_i,
			target_pos_three_i, target_pos_four_i};
		if (wb_req) begin
			if (wb_adr_i == `VSD_REG_CTRL) begin
				s_d.rdata = ctrl_word;
				if (wb_we_i && wb_sel_i[0]) begin
					s_d.variant = valve_state_decoder_pkg::variant_type'(
						wb_dat_i[`VSD_CTRL_VARIANT_LSB +: 2]);
					s_d.safe_pattern = wb_dat_i[`VSD_CTRL_SAFE_LSB +: 3];
				end
			end else if (wb_adr_i == `VSD_REG_OUT_IMAGE) begin
				s_d.rdata = {24'h0, s_q.process_output_image};
				if (wb_we_i && wb_sel_i[0]) begin
					s_d.process_output_image = wb_dat_i[7:0];
				end
			end else if (wb_adr_i == `VSD_REG_IN_IMAGE) begin
				// sensor bits low, valve state bits 80..83 placed at 19:16
				s_d.rdata = {12'h0, process_input_image[`VSD_IN_STATE_LSB +: 4],
					12'h0, process_input_image[3:0]};
			end else if (wb_adr_i == `VSD_REG_STATUS) begin
				s_d.rdata = status_word;
			end else begin
				s_d.rdata = 32'h0000_0000;
			end
		end
		// safety: fault beats link loss beats command
		if (internal_fault_i || supply_bad_i) begin
			{s_d.lower, s_d.upper, s_d.main} = 3'h0;
			s_d.localise = 1'b0;
		end else if (link_lost_i) begin
			{s_d.lower, s_d.upper, s_d.main} = s_q.safe_pattern & have;
			s_d.localise = 1'b0;
		end else begin
			{s_d.lower, s_d.upper, s_d.main} = want;
			s_d.localise = s_q.process_output_image[`VSD_OUT_LOCALISE];
		end
		// top indicator
		if (internal_fault_i || supply_bad_i) begin
			s_d.indicator = valve_state_decoder_pkg::IND_FAULT;
		end else if (link_lost_i) begin
			s_d.indicator = valve_state_decoder_pkg::IND_BUSFAIL;
		end else if (s_q.variant == valve_state_decoder_pkg::VARIANT_RAW) begin
			s_d.indicator = valve_state_decoder_pkg::IND_SENSOR;
		end else if (dec_state[0]) begin
			s_d.indicator = valve_state_decoder_pkg::IND_CLOSED;
		end else if (dec_state[1]) begin
			s_d.indicator = valve_state_decoder_pkg::IND_OPEN;
		end else if (dec_state[2]) begin
			s_d.indicator = valve_state_decoder_pkg::IND_UPPER;
		end else if (dec_state[3]) begin
			s_d.indicator = valve_state_decoder_pkg::IND_LOWER;
		end else begin
			s_d.indicator = valve_state_decoder_pkg::IND_UNKNOWN;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign wb_dat_o            = s_q.rdata;
	assign wb_ack_o            = s_q.ack;
	assign main_stroke_pilot_o = s_q.main;
	assign upper_lift_pilot_o  = s_q.upper;
	assign lower_lift_pilot_o  = s_q.lower;
	assign localise_o          = s_q.localise;
	assign indicator_o         = s_q.indicator;

endmodule : valve_state_decoder

// ===== src/valve_state_decoder_cfg.svh
/*
 constants for the valve state decoder: register offsets, field positions,
 reset values and decode patterns.
 assumes the includer wants plain `define macros; guard prevents re-entry.
*/
`ifndef VALVE_STATE_DECODER_CFG_SVH
`define VALVE_STATE_DECODER_CFG_SVH

// wishbone word offsets (byte addresses)
`define VSD_REG_CTRL        8'h00
`define VSD_REG_OUT_IMAGE   8'h04
`define VSD_REG_IN_IMAGE    8'h08
`define VSD_REG_STATUS      8'h0C

// control register fields
`define VSD_CTRL_VARIANT_LSB 0
`define VSD_CTRL_SAFE_LSB    4
`define VSD_CTRL_RESET       32'h0000_0000

// process output image bits
`define VSD_OUT_MAIN     0
`define VSD_OUT_UPPER    1
`define VSD_OUT_LOWER    2
`define VSD_OUT_LOCALISE 3

// valve-state bit position in the input image (offset 80)
`define VSD_IN_STATE_LSB 80
`define VSD_IN_WIDTH     84

// target patterns, written as bits one..four from msb to lsb
`define VSD_PAT_SA_CLOSED 4'hA
`define VSD_PAT_SA_OPEN   4'h1
`define VSD_PAT_V2_CLOSED 4'h8
`define VSD_PAT_V2_OPEN   4'h1
`define VSD_PAT_V2_UPPER  4'h4
`define VSD_PAT_V2_LOWER  4'hA
`define VSD_PAT_V3_CLOSED 4'hA
`define VSD_PAT_V3_OPEN   4'h1
`define VSD_PAT_V3_UPPER  4'h6
`define VSD_PAT_V3_LOWER  4'h8

`endif

// ===== src/valve_state_decoder_pkg.sv
/*
 types shared by the valve state decoder modules.
 assumes nothing beyond a systemverilog compiler.
*/
package valve_state_decoder_pkg;

	typedef enum logic [1:0] {
		VARIANT_SINGLE = 2'h0,
		VARIANT_DUAL   = 2'h1,
		VARIANT_LIFT   = 2'h2,
		VARIANT_RAW    = 2'h3
	} variant_type;

	typedef enum logic [2:0] {
		IND_UNKNOWN = 3'h0,
		IND_CLOSED  = 3'h1,
		IND_OPEN    = 3'h2,
		IND_UPPER   = 3'h3,
		IND_LOWER   = 3'h4,
		IND_SENSOR  = 3'h5,
		IND_BUSFAIL = 3'h6,
		IND_FAULT   = 3'h7
	} indicator_type;

endpackage : valve_state_decoder_pkg

// ===== src/decode_if.sv
/*
 carries targets and variant to the decode table and the state back.
 assumes both ends share clk_i.
*/
interface decode_if;
	logic [3:0]                          targets;
	valve_state_decoder_pkg::variant_type variant;
	logic [3:0]                          state;

	modport table_side (input targets, input variant, output state);
	modport user_side  (output targets, output variant, input state);
endinterface : decode_if

// ===== src/valve_decode_table.sv
/*
 registered decode table: maps four target bits to four valve-state bits.
 assumes targets are arranged bit one at msb down to bit four at lsb.
*/
`include "valve_state_decoder_cfg.svh"

module valve_decode_table (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// decode channel
	decode_if.table_side     dec
);

	typedef struct packed {
		logic [3:0] state;
	} table_state_type;

	table_state_type s_q;
	table_state_type s_d;

	always_comb begin
		s_d = s_q;
		// unmatched pattern leaves every state bit low
		s_d.state = 4'h0;
		case (dec.variant)
			valve_state_decoder_pkg::VARIANT_SINGLE: begin
				s_d.state[0] = (dec.targets == `VSD_PAT_SA_CLOSED);
				s_d.state[1] = (dec.targets == `VSD_PAT_SA_OPEN);
			end
			valve_state_decoder_pkg::VARIANT_DUAL: begin
				s_d.state[0] = (dec.targets == `VSD_PAT_V2_CLOSED);
				s_d.state[1] = (dec.targets == `VSD_PAT_V2_OPEN);
				s_d.state[2] = (dec.targets == `VSD_PAT_V2_UPPER);
				s_d.state[3] = (dec.targets == `VSD_PAT_V2_LOWER);
			end
			valve_state_decoder_pkg::VARIANT_LIFT: begin
				s_d.state[0] = (dec.targets == `VSD_PAT_V3_CLOSED);
				s_d.state[1] = (dec.targets == `VSD_PAT_V3_OPEN);
				s_d.state[2] = (dec.targets == `VSD_PAT_V3_UPPER);
				s_d.state[3] = (dec.targets == `VSD_PAT_V3_LOWER);
			end
			// raw variant leaves decoding to the controller
			default: begin
				s_d.state = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dec.state = s_q.state;

endmodule : valve_decode_table

// ===== tb/vsd_sva.sv
/* checker: decode, pilot safety and bus answer properties on top ports.
 assumes it is bound to valve_state_decoder with one clock domain. */
module vsd_sva (
	// clock, reset and bus
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	// sensors and supervision
	input wire logic       target_pos_one_i,
	input wire logic       target_pos_two_i,
	input wire logic       target_pos_three_i,
	input wire logic       target_pos_four_i,
	input wire logic       link_lost_i,
	input wire logic       internal_fault_i,
	input wire logic       supply_bad_i,
	// actuators and display
	input wire logic       main_stroke_pilot_o,
	input wire logic       upper_lift_pilot_o,
	input wire logic       lower_lift_pilot_o,
	input wire logic       localise_o,
	input wire logic [2:0] indicator_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire bad = internal_fault_i | supply_bad_i;
	wire [3:0] tgt = {target_pos_one_i, target_pos_two_i,
		target_pos_three_i, target_pos_four_i};
	// three quiet cycles let the target pass register and table
	sequence s_hold(p);
		(tgt == p && !bad && !link_lost_i)[*3];
	endsequence
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	AST_ACK_PULSE: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single pulse after request");
	AST_OPEN: assert property (
		s_hold(4'h1) |=> indicator_o inside {3'h2, 3'h5})
		else $error("open pattern not shown as open");
	AST_CLOSED: assert property (
		s_hold(4'hA) |=> indicator_o inside {3'h1, 3'h4, 3'h5})
		else $error("pattern 1010 shown wrongly");
	AST_UPPER: assert property (
		s_hold(4'h6) |=> indicator_o inside {3'h0, 3'h3, 3'h5})
		else $error("pattern 0110 shown wrongly");
	AST_NOMATCH: assert property (
		s_hold(4'hF) |=> indicator_o inside {3'h0, 3'h5})
		else $error("unmatched pattern shown as a state");
	AST_FAULT_OFF: assert property (
		bad |=> !(main_stroke_pilot_o || upper_lift_pilot_o
		|| lower_lift_pilot_o)) else $error("pilot on during fault");
	AST_FAULT_IND: assert property (
		bad |=> indicator_o == 3'h7) else $error("fault not shown");
	AST_LINK_IND: assert property (
		link_lost_i && !bad |=> indicator_o == 3'h6)
		else $error("link loss not shown");
	AST_LINK_LOC: assert property (
		link_lost_i || bad |=> !localise_o)
		else $error("localise active in safety state");
endmodule : vsd_sva

bind valve_state_decoder vsd_sva u_sva (.clk_i, .resetn_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .target_pos_one_i, .target_pos_two_i,
	.target_pos_three_i, .target_pos_four_i, .link_lost_i,
	.internal_fault_i, .supply_bad_i, .main_stroke_pilot_o,
	.upper_lift_pilot_o, .lower_lift_pilot_o, .localise_o, .indicator_o);

// ===== tb/plc_master.sv
/* controller-side wishbone master writing commands, reading images.
 assumes calls start right after a rising clock edge. */
module plc_master (
	// clock
	input  wire logic        clk_i,
	// wishbone master
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [7:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= '0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		{cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'h3, w, a, 4'hF, d};
		do @(posedge clk_i);
		while (ack_i !== 1'b1);
		r = dat_i;
		{cyc_o, stb_o, we_o} <= 3'h0;
		// stale data must not look valid once released
		dat_o <= ~d;
		@(posedge clk_i);
	endtask : xfer
endmodule : plc_master

// ===== tb/valve_state_decoder_tb.sv
/* bench for valve_state_decoder: registers, decode tables, pilots.
 assumes plc_master as bus partner and the bound checker. */
module valve_state_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        link_lost_i = 1'b0;
	logic        internal_fault_i = 1'b0;
	logic        supply_bad_i = 1'b0;
	logic [3:0]  tgt = 4'h0;
	logic        cyc, stb, we, ack, mp, up, lp, loc;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, r;
	logic [2:0]  ind;
	int          n_errors = 0;
	int          num_checks = 0;
	int          cycles = 0;

	valve_state_decoder dut (.clk_i, .resetn_i, .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.target_pos_one_i(tgt[3]), .target_pos_two_i(tgt[2]),
		.target_pos_three_i(tgt[1]), .target_pos_four_i(tgt[0]),
		.link_lost_i, .internal_fault_i, .supply_bad_i,
		.main_stroke_pilot_o(mp), .upper_lift_pilot_o(up),
		.lower_lift_pilot_o(lp), .localise_o(loc), .indicator_o(ind));
	plc_master u_plc (.clk_i, .cyc_o(cyc), .stb_o(stb), .we_o(we),
		.adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));

	initial forever #5 clk_i = ~clk_i;

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic give_verdict;
		$display("checks=%0d errors=%0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	// state bits closed, open, upper, lower from lsb up
	function automatic logic [3:0] exp_st(logic [1:0] v, logic [3:0] t);
		case (v)
			2'h0: return {2'h0, t == 4'h1, t == 4'hA};
			2'h1: return {t == 4'hA, t == 4'h4, t == 4'h1, t == 4'h8};
			2'h2: return {t == 4'h8, t == 4'h6, t == 4'h1, t == 4'hA};
			default: return 4'h0;
		endcase
	endfunction : exp_st

	task automatic t_regs;
		u_plc.xfer(1'b0, 8'h00, 32'h0, r);
		chk(r, 32'h0);
		u_plc.xfer(1'b1, 8'h08, 32'hFFFF_FFFF, r);
		u_plc.xfer(1'b0, 8'h08, 32'h0, r);
		chk(r, 32'h0);
		u_plc.xfer(1'b0, 8'h10, 32'h0, r);
		chk(r, 32'h0);
	endtask : t_regs

	task automatic t_decode;
		logic [3:0] pats [6] = '{4'hA, 4'h1, 4'h8, 4'h4, 4'h6, 4'hF};
		logic [3:0] s;
		logic [3:0] rev;
		logic [2:0] e_ind;
		for (int v = 0; v < 4; v++) begin
			u_plc.xfer(1'b1, 8'h00, 32'(v), r);
			foreach (pats[i]) begin
				tgt <= pats[i];
				repeat (4) @(posedge clk_i);
				s = exp_st(2'(v), pats[i]);
				// bit one of the pattern lands at image offset 0
				rev = {<<{pats[i]}};
				e_ind = v == 3 ? 3'h5 : s[0] ? 3'h1 : s[1] ? 3'h2
					: s[2] ? 3'h3 : s[3] ? 3'h4 : 3'h0;
				u_plc.xfer(1'b0, 8'h08, 32'h0, r);
				chk(r, {12'h0, s, 12'h0, rev});
				chk(32'(ind), 32'(e_ind));
			end
		end
	endtask : t_decode

	task automatic t_pilots;
		for (int v = 0; v < 3; v++) begin
			u_plc.xfer(1'b1, 8'h00, 32'(v), r);
			u_plc.xfer(1'b1, 8'h04, 32'hFF, r);
			@(posedge clk_i);
			chk(32'({lp, up, mp, loc, ind}), v == 0 ? 7'h18 : 7'h78);
		end
		// variant two with main and lower as the safety pattern
		u_plc.xfer(1'b1, 8'h00, 32'h51, r);
		u_plc.xfer(1'b1, 8'h04, 32'h0A, r);
		@(posedge clk_i);
		chk(32'({lp, up, mp, loc, ind}), 7'h28);
		u_plc.xfer(1'b0, 8'h00, 32'h0, r);
		chk(r, 32'h0000_0051);
		u_plc.xfer(1'b0, 8'h04, 32'h0, r);
		chk(r, 32'h0000_000A);
		link_lost_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(32'({lp, up, mp, loc, ind}), 7'h56);
		// status shows link loss in bit 2 and the indicator code
		u_plc.xfer(1'b0, 8'h0C, 32'h0, r);
		chk(r, 32'h0000_0604);
		internal_fault_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(32'({lp, up, mp, loc, ind}), 7'h07);
		u_plc.xfer(1'b0, 8'h0C, 32'h0, r);
		chk(r, 32'h0000_070C);
		{link_lost_i, internal_fault_i, supply_bad_i} <= 3'h1;
		repeat (2) @(posedge clk_i);
		chk(32'({lp, up, mp, loc, ind}), 7'h07);
		supply_bad_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(32'({lp, up, mp, loc, ind}), 7'h28);
	endtask : t_pilots

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_decode();
		t_pilots();
		give_verdict();
	end
endmodule : valve_state_decoder_tb
